// ---- hw/dmd_pkg.sv ----
// Constants and types shared by the data memory space decoder.
package dmd_pkg;
  // Address ranges of the internal data spaces.
  localparam logic [7:0] DIRECT_RAM_TOP = 8'h7f; // Highest byte of lower main RAM.
  localparam logic [7:0] BANK_AREA_TOP = 8'h1f; // Highest byte of the working register banks.
  localparam logic [7:0] BIT_AREA_LO = 8'h20; // First bit-addressable byte.
  localparam logic [7:0] BIT_AREA_HI = 8'h2f; // Last bit-addressable byte.
  localparam logic [15:0] AUX_TOP = 16'h00ff; // Highest pointer value that maps to auxiliary RAM.
  localparam logic [15:0] INT_CODE_TOP = 16'h7fff; // Highest internally fetched code address.
  localparam int BANK_SHIFT = 3; // Eight bytes per register bank.
  localparam int BUS_CYCLES = 4; // Clocks the read or write strobe stays low in one external data bus cycle.
  localparam logic [2:0] BUS_LAST = 3'h3; // Final count of an external bus cycle.

  // Operand addressing methods.
  typedef enum logic [2:0]
  {
    DMD_AM_REGISTER = 3'h0,
    DMD_AM_DIRECT = 3'h1,
    DMD_AM_INDIRECT = 3'h2,
    DMD_AM_IMMEDIATE = 3'h3,
    DMD_AM_BASE_INDEX = 3'h4
  } dmd_mode_e;

  // Instruction classes that steer routing.
  typedef enum logic [1:0]
  {
    DMD_OP_PLAIN = 2'h0,
    DMD_OP_EXT_MOVE = 2'h1,
    DMD_OP_CODE_READ = 2'h2
  } dmd_op_e;

  // Access targets.
  typedef enum logic [2:0]
  {
    DMD_TGT_NONE = 3'h0,
    DMD_TGT_MAIN_LO = 3'h1,
    DMD_TGT_MAIN_HI = 3'h2,
    DMD_TGT_AUX = 3'h3,
    DMD_TGT_SFA = 3'h4,
    DMD_TGT_EXT = 3'h5,
    DMD_TGT_CODE = 3'h6
  } dmd_tgt_e;

  // External bus cycle states, one-hot.
  typedef enum logic [3:0]
  {
    DMD_BUS_IDLE = 4'h1,
    DMD_BUS_ADDR = 4'h2,
    DMD_BUS_DATA = 4'h4,
    DMD_BUS_DONE = 4'h8
  } dmd_bus_e;
endpackage : dmd_pkg

// ---- hw/dmd_ext_bus.sv ----
// External data memory bus cycle engine on the multiplexed ports.
module dmd_ext_bus (
  input wire logic sys_clk, // Core clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic start, // One-cycle request for a bus cycle.
  input wire logic wr, // High for a write cycle.
  input wire logic [15:0] addr, // Full 16-bit address.
  input wire logic [7:0] wdata, // Write data.
  input wire logic [7:0] low_addr_data_port_in, // Synchronised low port level.
  output logic [7:0] low_addr_data_port_out, // Low port drive value.
  output logic low_addr_data_port_oe, // Low port output enable.
  output logic [7:0] high_address_port_out, // High port drive value.
  output logic ext_wr_n, // Write strobe, active low.
  output logic ext_rd_n, // Read strobe, active low.
  output logic ale, // Address latch enable.
  output logic busy, // Bus cycle in progress.
  output logic done, // One-cycle pulse when the cycle ends.
  output logic [7:0] rdata // Data captured on a read.
);
  dmd_pkg::dmd_bus_e st_r, st_nxt; // Cycle state.
  logic [2:0] cnt_r, cnt_nxt; // Clock count within a phase.
  logic wr_r, wr_nxt; // Latched direction.
  logic [15:0] addr_r, addr_nxt; // Latched address.
  logic [7:0] wd_r, wd_nxt; // Latched write data.
  logic [7:0] rd_r, rd_nxt; // Captured read data.

  // Next-state logic: address phase, strobe phase, then release.
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    case (st_r)
      dmd_pkg::DMD_BUS_IDLE:
      begin
        if (start)
        begin
          st_nxt = dmd_pkg::DMD_BUS_ADDR;
          wr_nxt = wr;
          addr_nxt = addr;
          wd_nxt = wdata;
          cnt_nxt = 3'h0;
        end
      end
      dmd_pkg::DMD_BUS_ADDR:
      begin
        st_nxt = dmd_pkg::DMD_BUS_DATA;
      end
      dmd_pkg::DMD_BUS_DATA:
      begin
        // The strobe is held for several clocks so slow memories can answer.
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == dmd_pkg::BUS_LAST)
        begin
          st_nxt = dmd_pkg::DMD_BUS_DONE;
          if (!wr_r)
          begin
            rd_nxt = low_addr_data_port_in;
          end
        end
      end
      dmd_pkg::DMD_BUS_DONE:
      begin
        st_nxt = dmd_pkg::DMD_BUS_IDLE;
      end
      default:
      begin
        st_nxt = dmd_pkg::DMD_BUS_IDLE;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_r <= dmd_pkg::DMD_BUS_IDLE;
      cnt_r <= 3'h0;
      wr_r <= 1'b0;
      addr_r <= 16'h0000;
      wd_r <= 8'h00;
      rd_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Pin drive follows the state: low address byte first, then data.
  assign ale = (st_r == dmd_pkg::DMD_BUS_ADDR);
  assign low_addr_data_port_out = ale ? addr_r[7:0] : wd_r;
  assign low_addr_data_port_oe = ale || (st_r == dmd_pkg::DMD_BUS_DATA && wr_r);
  assign high_address_port_out = addr_r[15:8];
  assign ext_wr_n = !(st_r == dmd_pkg::DMD_BUS_DATA && wr_r);
  assign ext_rd_n = !(st_r == dmd_pkg::DMD_BUS_DATA && !wr_r);
  assign busy = (st_r != dmd_pkg::DMD_BUS_IDLE);
  assign done = (st_r == dmd_pkg::DMD_BUS_DONE);
  assign rdata = rd_r;
endmodule : dmd_ext_bus

// ---- hw/dmd_decoder.sv ----
// Data memory space decoder and access router for the CPU core.
module dmd_decoder (
  input wire logic sys_clk, // Core clock, 10 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic req, // One-cycle access request.
  input wire logic req_wr, // High for a write access.
  input wire logic req_dest, // Operand is a destination.
  input wire logic req_rmw, // Non-move operation on the destination.
  input wire logic [2:0] req_mode, // Addressing method.
  input wire logic [1:0] req_op, // Instruction class.
  input wire logic [7:0] req_addr, // Direct address or register number.
  input wire logic req_ptr_sel, // Pointer register one when high.
  input wire logic req_use_wide, // Use the wide data pointer.
  input wire logic [15:0] wide_data_pointer, // Wide data pointer value.
  input wire logic [15:0] code_base, // Table read base register.
  input wire logic [7:0] code_index, // Table read index register.
  input wire logic [7:0] req_wdata, // Write data.
  input wire logic [1:0] bank_select, // Bank field of the status register.
  input wire logic fetch_req, // Code fetch request.
  input wire logic [15:0] fetch_addr, // Code fetch address.
  input wire logic exec_external, // Current code runs from external memory.
  input wire logic protect_on, // Program memory protection activated.
  input wire logic external_access_select, // Access select pin.
  input wire logic [7:0] low_addr_data_port_in, // Low port pin level.
  output logic [7:0] low_addr_data_port_out, // Low port drive value.
  output logic low_addr_data_port_oe, // Low port output enable.
  output logic [7:0] high_address_port_out, // High port drive value.
  output logic ext_wr_n, // Write strobe, active low.
  output logic ext_rd_n, // Read strobe, active low.
  output logic ale, // Address latch enable.
  output logic [2:0] tgt, // Target of the current access.
  output logic [7:0] ram_addr, // Main or auxiliary RAM address.
  output logic [6:0] sfa_addr, // Special area register index.
  output logic ram_rd, // Read strobe to the chosen internal array.
  output logic ram_wr, // Write strobe to the chosen internal array.
  output logic bit_area, // Address lies in the bit-addressable bytes.
  output logic [15:0] code_addr, // Table read or fetch address.
  output logic code_internal, // Code address goes to internal memory.
  output logic ack, // One-cycle pulse: access complete.
  output logic refused, // One-cycle pulse: access refused.
  output logic [7:0] ext_rdata, // Read data from the external bus.
  output logic stall // Core must wait for the external bus.
);
  logic [7:0] ram_r [0:255]; // Copy of main RAM used for pointer fetch.
  logic ea1_r, ea1_nxt; // Access select, first sync stage.
  logic ea2_r, ea2_nxt; // Access select, second sync stage.
  logic ea_lat_r, ea_lat_nxt; // Access select caught at reset release.
  logic rst_d_r, rst_d_nxt; // Reset seen last cycle.
  logic [7:0] p0a_r, p0a_nxt; // Low port pins, first sync stage.
  logic [7:0] p0b_r, p0b_nxt; // Low port pins, second sync stage.
  logic [7:0] bank_base; // Byte offset of the active bank.
  logic [7:0] ptr; // Indirect pointer byte.
  logic [15:0] xptr; // External move pointer.
  logic [15:0] caddr; // Table read address.
  logic bus_start; // Launch an external cycle.
  logic bus_busy; // External cycle running.
  logic bus_done; // External cycle finished.
  logic [2:0] tgt_c; // Combinational target.
  logic [7:0] ram_addr_c; // Combinational RAM address.
  logic bad; // Combinational refusal.

  // Pins pass two flip-flops; the strap is caught in the cycle after reset.
  always_comb
  begin
    ea1_nxt = external_access_select;
    ea2_nxt = ea1_r;
    p0a_nxt = low_addr_data_port_in;
    p0b_nxt = p0a_r;
    rst_d_nxt = srst;
    ea_lat_nxt = rst_d_r ? ea2_r : ea_lat_r;
  end

  // Registers for pins and strap.
  // The synchronisers keep sampling during reset, so the strap is settled when reset ends.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ea1_r <= ea1_nxt;
      ea2_r <= ea2_nxt;
      p0a_r <= p0a_nxt;
      p0b_r <= p0b_nxt;
      rst_d_r <= 1'b1;
      ea_lat_r <= 1'b0;
    end
    else
    begin
      ea1_r <= ea1_nxt;
      ea2_r <= ea2_nxt;
      p0a_r <= p0a_nxt;
      p0b_r <= p0b_nxt;
      rst_d_r <= rst_d_nxt;
      ea_lat_r <= ea_lat_nxt;
    end
  end

  // Shadow of main RAM; the decoder reads bank registers zero and one from it.
  // Keeping a local copy avoids a second read port on the core's array.
  always_ff @(posedge sys_clk)
  begin
    if (ram_wr && (tgt == dmd_pkg::DMD_TGT_MAIN_LO || tgt == dmd_pkg::DMD_TGT_MAIN_HI))
    begin
      ram_r[ram_addr] <= req_wdata;
    end
  end

  // Bank base: two status bits, eight bytes per bank, inside bytes 0-31.
  assign bank_base = {3'h0, bank_select, 3'h0};
  // Indirect pointer is register zero or one of the active bank.
  assign ptr = ram_r[bank_base | {7'h00, req_ptr_sel}];
  // External moves use the wide pointer or a zero-extended byte pointer.
  assign xptr = req_use_wide ? wide_data_pointer : {8'h00, ptr};
  // Table reads form base plus index.
  assign caddr = code_base + {8'h00, code_index};

  // Target decode.
  always_comb
  begin
    tgt_c = dmd_pkg::DMD_TGT_NONE;
    ram_addr_c = 8'h00;
    bad = 1'b0;
    if (req_op == dmd_pkg::DMD_OP_EXT_MOVE)
    begin
      // External data is reached only indirectly.
      if (req_mode != dmd_pkg::DMD_AM_INDIRECT)
      begin
        bad = 1'b1;
      end
      else if (xptr <= dmd_pkg::AUX_TOP)
      begin
        tgt_c = dmd_pkg::DMD_TGT_AUX;
        ram_addr_c = xptr[7:0];
      end
      else
      begin
        tgt_c = dmd_pkg::DMD_TGT_EXT;
      end
    end
    else if (req_op == dmd_pkg::DMD_OP_CODE_READ)
    begin
      if (req_mode != dmd_pkg::DMD_AM_BASE_INDEX)
      begin
        bad = 1'b1;
      end
      else if (protect_on && exec_external && caddr <= dmd_pkg::INT_CODE_TOP && ea_lat_r)
      begin
        bad = 1'b1;
      end
      else
      begin
        tgt_c = dmd_pkg::DMD_TGT_CODE;
      end
    end
    else if (req_dest && (req_mode == dmd_pkg::DMD_AM_IMMEDIATE || req_mode == dmd_pkg::DMD_AM_BASE_INDEX))
    begin
      bad = 1'b1;
    end
    else if (req_mode == dmd_pkg::DMD_AM_REGISTER)
    begin
      tgt_c = dmd_pkg::DMD_TGT_MAIN_LO;
      ram_addr_c = bank_base | {5'h00, req_addr[2:0]};
    end
    else if (req_mode == dmd_pkg::DMD_AM_DIRECT)
    begin
      // Upper direct addresses select the special area, never upper RAM.
      if (req_addr <= dmd_pkg::DIRECT_RAM_TOP)
      begin
        tgt_c = dmd_pkg::DMD_TGT_MAIN_LO;
        ram_addr_c = req_addr;
      end
      else
      begin
        tgt_c = dmd_pkg::DMD_TGT_SFA;
      end
    end
    else if (req_mode == dmd_pkg::DMD_AM_INDIRECT)
    begin
      // Indirect covers all 256 bytes, so a stack may sit anywhere.
      ram_addr_c = ptr;
      tgt_c = (ptr <= dmd_pkg::DIRECT_RAM_TOP) ? dmd_pkg::DMD_TGT_MAIN_LO : dmd_pkg::DMD_TGT_MAIN_HI;
    end
    else
    begin
      tgt_c = dmd_pkg::DMD_TGT_NONE; // Immediate source needs no memory.
    end
  end

  // Outputs to the internal arrays.
  assign tgt = req ? tgt_c : dmd_pkg::DMD_TGT_NONE;
  assign ram_addr = ram_addr_c;
  assign sfa_addr = req_addr[6:0];
  // A non-move destination is read as a source as well as written.
  assign ram_rd = req && !bad && tgt_c != dmd_pkg::DMD_TGT_EXT && (!req_wr || req_rmw);
  assign ram_wr = req && !bad && req_wr && tgt_c != dmd_pkg::DMD_TGT_EXT && tgt_c != dmd_pkg::DMD_TGT_CODE;
  assign bit_area = ram_addr_c >= dmd_pkg::BIT_AREA_LO && ram_addr_c <= dmd_pkg::BIT_AREA_HI;
  // Code fetches split on the latched strap; table reads use their own sum.
  assign code_addr = (req && req_op == dmd_pkg::DMD_OP_CODE_READ) ? caddr : fetch_addr;
  assign code_internal = ea_lat_r && code_addr <= dmd_pkg::INT_CODE_TOP && (fetch_req || !bad);
  // Only external targets start the bus, so auxiliary hits leave the pins idle.
  assign bus_start = req && !bad && tgt_c == dmd_pkg::DMD_TGT_EXT && !bus_busy;
  assign stall = bus_busy || (req && tgt_c == dmd_pkg::DMD_TGT_EXT && !bad);
  assign ack = (req && !bad && tgt_c != dmd_pkg::DMD_TGT_EXT) || bus_done;
  assign refused = req && bad;

  // External bus engine for pointers above the auxiliary range.
  dmd_ext_bus u_bus (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(bus_start),
    .wr(req_wr),
    .addr(xptr),
    .wdata(req_wdata),
    .low_addr_data_port_in(p0b_r),
    .low_addr_data_port_out(low_addr_data_port_out),
    .low_addr_data_port_oe(low_addr_data_port_oe),
    .high_address_port_out(high_address_port_out),
    .ext_wr_n(ext_wr_n),
    .ext_rd_n(ext_rd_n),
    .ale(ale),
    .busy(bus_busy),
    .done(bus_done),
    .rdata(ext_rdata)
  );
endmodule : dmd_decoder

// ---- verification/dmd_decoder_props.sv ----
// Port checker for the data memory space decoder.
module dmd_decoder_props (
  input wire logic sys_clk, // Core clock.
  input wire logic srst, // Synchronous reset.
  input wire logic req, // Access request.
  input wire logic req_dest, // Destination operand.
  input wire logic [2:0] req_mode, // Addressing method.
  input wire logic [1:0] req_op, // Instruction class.
  input wire logic [7:0] req_addr, // Direct address.
  input wire logic req_use_wide, // Wide pointer used.
  input wire logic [15:0] wide_data_pointer, // Wide pointer.
  input wire logic [15:0] code_base, // Table base.
  input wire logic [7:0] code_index, // Table index.
  input wire logic [1:0] bank_select, // Bank field.
  input wire logic exec_external, // Code runs externally.
  input wire logic protect_on, // Protection active.
  input wire logic external_access_select, // Strap pin.
  input wire logic [7:0] high_address_port_out, // High port.
  input wire logic ext_wr_n, // Write strobe.
  input wire logic ext_rd_n, // Read strobe.
  input wire logic ale, // Address latch enable.
  input wire logic [2:0] tgt, // Target.
  input wire logic [7:0] ram_addr, // RAM address.
  input wire logic [6:0] sfa_addr, // Special area index.
  input wire logic [15:0] code_addr, // Table address.
  input wire logic refused, // Refusal.
  input wire logic stall // Bus wait.
);
  // All checks share the core clock and are muted in reset.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  logic [15:0] tab_sum; // Address a table read forms.
  logic plain; // Plain instruction in flight.
  logic xm; // External move in flight.
  // Helper terms keep the properties short.
  assign tab_sum = code_base + {8'h00, code_index};
  assign plain = req && (req_op == dmd_pkg::DMD_OP_PLAIN);
  assign xm = req && (req_op == dmd_pkg::DMD_OP_EXT_MOVE);
  chk_direct_low: assert property (plain && req_mode == dmd_pkg::DMD_AM_DIRECT && !req_addr[7]
    |-> tgt == dmd_pkg::DMD_TGT_MAIN_LO && ram_addr == req_addr) else $error("direct low miss");
  chk_direct_special: assert property (plain && req_mode == dmd_pkg::DMD_AM_DIRECT && req_addr[7]
    |-> tgt == dmd_pkg::DMD_TGT_SFA && sfa_addr == req_addr[6:0]) else $error("direct high miss");
  chk_bank_offset: assert property (plain && req_mode == dmd_pkg::DMD_AM_REGISTER
    |-> ram_addr == {3'h0, bank_select, req_addr[2:0]}) else $error("bank offset wrong");
  chk_aux_low: assert property (xm && req_mode == dmd_pkg::DMD_AM_INDIRECT && req_use_wide
    && wide_data_pointer <= dmd_pkg::AUX_TOP |-> tgt == dmd_pkg::DMD_TGT_AUX) else $error("aux miss");
  chk_aux_quiet: assert property (tgt == dmd_pkg::DMD_TGT_AUX && !exec_external
    |-> ext_rd_n && ext_wr_n && !ale && $stable(high_address_port_out)) else $error("aux moved pins");
  chk_bus_start: assert property ($rose(stall) && xm
    |=> ale && high_address_port_out == wide_data_pointer[15:8]) else $error("bus start wrong");
  chk_read_strobe: assert property ($fell(ext_rd_n) |-> !ext_rd_n [*4] ##1 ext_rd_n)
    else $error("read strobe length");
  chk_ext_refuse: assert property (xm && req_mode != dmd_pkg::DMD_AM_INDIRECT |-> refused)
    else $error("ext move not refused");
  chk_dest_refuse: assert property (req && req_dest && req_mode inside
    {dmd_pkg::DMD_AM_IMMEDIATE, dmd_pkg::DMD_AM_BASE_INDEX} |-> refused) else $error("dest not refused");
  chk_code_guard: assert property (req && req_op == dmd_pkg::DMD_OP_CODE_READ && protect_on
    && exec_external && external_access_select && tab_sum <= dmd_pkg::INT_CODE_TOP |-> refused)
    else $error("protected read passed");
  chk_table_sum: assert property (req && req_op == dmd_pkg::DMD_OP_CODE_READ && !refused
    |-> code_addr == tab_sum) else $error("table address wrong");
  cov_bus: cover property ($rose(stall));
  cov_refuse: cover property (refused);
  cov_aux: cover property (tgt == dmd_pkg::DMD_TGT_AUX);
endmodule : dmd_decoder_props

// ---- verification/dmd_ext_mem.sv ----
// External data memory model on the multiplexed port bus.
module dmd_ext_mem (
  input wire logic sys_clk, // Core clock.
  input wire logic ale, // Address latch enable.
  input wire logic [7:0] bus, // Resolved low port level.
  input wire logic [7:0] high_address_port_out, // Upper address.
  input wire logic ext_wr_n, // Write strobe, active low.
  input wire logic ext_rd_n, // Read strobe, active low.
  output logic [7:0] mem_q, // Data offered on a read.
  output logic mem_oe // High while the model drives the port.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [16]; // Small window; upper address bits alias.
  logic [15:0] addr_r = 16'h0000; // Address taken during ale.
  // Address comes from both ports in the latch cycle, data under the strobe.
  always_ff @(posedge sys_clk)
  begin
    if (ale)
      addr_r <= {high_address_port_out, bus};
    if (!ext_wr_n)
      mem[addr_r[3:0]] <= bus;
  end
  // The port is driven only while the read strobe is low.
  assign mem_oe = !ext_rd_n;
  assign mem_q = mem[addr_r[3:0]];
endmodule : dmd_ext_mem

// ---- verification/dmd_decoder_bench.sv ----
// Self-checking bench for the data memory space decoder.
module dmd_decoder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, srst = 1'b1; // Clock and reset.
  logic req = 1'b0, req_wr = 1'b0, req_dest = 1'b0, req_ptr_sel = 1'b0; // Request flags.
  logic req_rmw = 1'b0; // Read-modify-write is not exercised.
  logic req_use_wide = 1'b0, fetch_req = 1'b0, exec_external = 1'b0, protect_on = 1'b0; // Modes.
  logic external_access_select = 1'b1; // Strap high: split code space.
  logic [2:0] req_mode = 3'h0; // Addressing method.
  logic [1:0] req_op = 2'h0, bank_select = 2'h0; // Class and bank.
  logic [7:0] req_addr = 8'h00, code_index = 8'h00, req_wdata = 8'h00; // Byte inputs.
  logic [15:0] wide_data_pointer = 16'h0000, code_base = 16'h0000, fetch_addr = 16'h0000; // Words.
  logic [7:0] low_addr_data_port_out, high_address_port_out, ram_addr, ext_rdata, mem_q; // Outputs.
  logic low_addr_data_port_oe, ext_wr_n, ext_rd_n, ale, ram_rd, ram_wr, bit_area, mem_oe; // Strobes.
  logic code_internal, ack, refused, stall; // Answers.
  logic [2:0] tgt; // Target.
  logic [6:0] sfa_addr; // Special area index.
  logic [15:0] code_addr; // Table address.
  logic [7:0] last_r = 8'h00; // Last low port level.
  wire logic [7:0] bus; // Resolved low port level.
  logic [2:0] g_tgt; // Captured target.
  logic [7:0] g_ram; // Captured RAM address.
  logic [6:0] g_sfa; // Captured special index.
  logic [15:0] g_code; // Captured table address.
  logic g_ref, g_bit, g_int, g_quiet; // Captured flags.
  int error_cnt = 0, compares = 0; // Tallies.
  logic [7:0] dirs [5] = '{8'h1f, 8'h20, 8'h2f, 8'h7f, 8'h80}; // Direct probe addresses.
  // A released port shows the inverse of its last level, so stale data cannot match.
  assign bus = low_addr_data_port_oe ? low_addr_data_port_out : (mem_oe ? mem_q : ~last_r);
  always @(posedge sys_clk) last_r <= bus;
  always #50 sys_clk = ~sys_clk;
  dmd_decoder u_dmd_decoder (.sys_clk, .srst, .req, .req_wr, .req_dest, .req_rmw, .req_mode, .req_op,
    .req_addr, .req_ptr_sel, .req_use_wide, .wide_data_pointer, .code_base, .code_index, .req_wdata,
    .bank_select, .fetch_req, .fetch_addr, .exec_external, .protect_on, .external_access_select,
    .low_addr_data_port_in(bus), .low_addr_data_port_out, .low_addr_data_port_oe, .high_address_port_out,
    .ext_wr_n, .ext_rd_n, .ale, .tgt, .ram_addr, .sfa_addr, .ram_rd, .ram_wr, .bit_area, .code_addr,
    .code_internal, .ack, .refused, .ext_rdata, .stall);
  dmd_ext_mem u_dmd_ext_mem (.sys_clk, .ale, .bus, .high_address_port_out, .ext_wr_n, .ext_rd_n,
    .mem_q, .mem_oe);
  // Prints the tallies and the verdict, then stops.
  task automatic final_report();
    $display("Checks %0d, errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  // Compares one value and counts the outcome.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds one request until its answer, bounded; external cycles take several clocks.
  task automatic acc(input logic [2:0] m, input logic [1:0] op, input logic [7:0] a, input logic wr);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= 1'b1;
    req_mode <= m;
    req_op <= op;
    req_addr <= a;
    req_wr <= wr;
    @(negedge sys_clk);
    while (ack !== 1'b1 && refused !== 1'b1)
    begin
      if (n++ > 20)
      begin
        error_cnt++;
        final_report();
      end
      @(negedge sys_clk);
    end
    {g_tgt, g_ram, g_sfa, g_code, g_ref, g_bit, g_int} = {tgt, ram_addr, sfa_addr, code_addr, refused,
      bit_area, code_internal};
    g_quiet = ext_rd_n & ext_wr_n & !ale & !low_addr_data_port_oe;
    @(posedge sys_clk);
    req <= 1'b0;
  endtask : acc
  // Loads distinct pointers into every bank, then reads through bank one.
  task automatic t_bank();
    for (int i = 0; i < 4; i++)
    begin
      bank_select <= 2'(i);
      req_wdata <= {6'h30, 2'(i)};
      acc(dmd_pkg::DMD_AM_REGISTER, dmd_pkg::DMD_OP_PLAIN, 8'h00, 1'b1);
      chk(16'(g_ram), 16'(i * 8));
      req_wdata <= {6'h10, 2'(i)};
      acc(dmd_pkg::DMD_AM_REGISTER, dmd_pkg::DMD_OP_PLAIN, 8'h01, 1'b1);
      chk(16'(g_ram), 16'(i * 8 + 1));
    end
    bank_select <= 2'h1;
    acc(dmd_pkg::DMD_AM_INDIRECT, dmd_pkg::DMD_OP_PLAIN, 8'h00, 1'b0);
    chk({5'h00, g_tgt, g_ram}, {5'h00, dmd_pkg::DMD_TGT_MAIN_HI, 8'hc1});
    req_ptr_sel <= 1'b1;
    acc(dmd_pkg::DMD_AM_INDIRECT, dmd_pkg::DMD_OP_PLAIN, 8'h00, 1'b0);
    chk({5'h00, g_tgt, g_ram}, {5'h00, dmd_pkg::DMD_TGT_MAIN_LO, 8'h41});
  endtask : t_bank
  // Direct addresses around the bit area and the special area boundary.
  task automatic t_direct();
    foreach (dirs[k])
    begin
      acc(dmd_pkg::DMD_AM_DIRECT, dmd_pkg::DMD_OP_PLAIN, dirs[k], 1'b0);
      chk(16'(g_tgt), dirs[k][7] ? 16'(dmd_pkg::DMD_TGT_SFA) : 16'(dmd_pkg::DMD_TGT_MAIN_LO));
      chk(16'(g_bit), 16'(dirs[k] inside {[8'h20:8'h2f]}));
    end
    chk(16'(g_sfa), 16'h0000);
  endtask : t_direct
  // Auxiliary hits stay off the pins; a wide pointer above the top runs the bus.
  task automatic t_ext();
    req_use_wide <= 1'b1;
    wide_data_pointer <= 16'h00ff;
    acc(dmd_pkg::DMD_AM_INDIRECT, dmd_pkg::DMD_OP_EXT_MOVE, 8'h00, 1'b1);
    chk({4'h0, g_quiet, g_tgt, g_ram}, {4'h1, dmd_pkg::DMD_TGT_AUX, 8'hff});
    req_use_wide <= 1'b0;
    acc(dmd_pkg::DMD_AM_INDIRECT, dmd_pkg::DMD_OP_EXT_MOVE, 8'h00, 1'b0);
    chk({5'h00, g_tgt, g_ram}, {5'h00, dmd_pkg::DMD_TGT_AUX, 8'h41});
    req_use_wide <= 1'b1;
    wide_data_pointer <= 16'h1234;
    req_wdata <= 8'ha5;
    acc(dmd_pkg::DMD_AM_INDIRECT, dmd_pkg::DMD_OP_EXT_MOVE, 8'h00, 1'b1);
    chk(16'(u_dmd_ext_mem.mem[4]), 16'h00a5);
    acc(dmd_pkg::DMD_AM_INDIRECT, dmd_pkg::DMD_OP_EXT_MOVE, 8'h00, 1'b0);
    chk(16'(ext_rdata), 16'h00a5);
    acc(dmd_pkg::DMD_AM_DIRECT, dmd_pkg::DMD_OP_EXT_MOVE, 8'h10, 1'b0);
    chk(16'(g_ref), 16'h0001);
    req_dest <= 1'b1;
    acc(dmd_pkg::DMD_AM_IMMEDIATE, dmd_pkg::DMD_OP_PLAIN, 8'h10, 1'b1);
    chk(16'(g_ref), 16'h0001);
    acc(dmd_pkg::DMD_AM_REGISTER, dmd_pkg::DMD_OP_PLAIN, 8'h02, 1'b1);
    chk(16'(g_ref), 16'h0000);
    req_dest <= 1'b0;
  endtask : t_ext
  // Table reads under protection from both code spaces, then code fetch split.
  task automatic t_code();
    code_base <= 16'h7000;
    code_index <= 8'h10;
    protect_on <= 1'b1;
    exec_external <= 1'b1;
    acc(dmd_pkg::DMD_AM_BASE_INDEX, dmd_pkg::DMD_OP_CODE_READ, 8'h00, 1'b0);
    chk(16'(g_ref), 16'h0001);
    exec_external <= 1'b0;
    acc(dmd_pkg::DMD_AM_BASE_INDEX, dmd_pkg::DMD_OP_CODE_READ, 8'h00, 1'b0);
    chk({g_code[14:0], g_ref}, {15'h7010, 1'b0});
    protect_on <= 1'b0;
    exec_external <= 1'b1;
    acc(dmd_pkg::DMD_AM_BASE_INDEX, dmd_pkg::DMD_OP_CODE_READ, 8'h00, 1'b0);
    chk(16'(g_ref), 16'h0000);
    acc(dmd_pkg::DMD_AM_DIRECT, dmd_pkg::DMD_OP_CODE_READ, 8'h00, 1'b0);
    chk(16'(g_ref), 16'h0001);
    fetch_req <= 1'b1;
    fetch_addr <= 16'h7fff;
    @(negedge sys_clk);
    chk(16'(code_internal), 16'h0001);
    @(posedge sys_clk);
    fetch_addr <= 16'h8000;
    @(negedge sys_clk);
    chk(16'(code_internal), 16'h0000);
  endtask : t_code
  // Main sequence: reset, let the strap settle, then the scenarios.
  initial
  begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    t_bank();
    t_direct();
    t_ext();
    t_code();
    final_report();
  end
endmodule : dmd_decoder_bench
bind dmd_decoder dmd_decoder_props u_dmd_decoder_props (.sys_clk, .srst, .req, .req_dest, .req_mode, .req_op,
  .req_addr, .req_use_wide, .wide_data_pointer, .code_base, .code_index, .bank_select, .exec_external,
  .protect_on, .external_access_select, .high_address_port_out, .ext_wr_n, .ext_rd_n, .ale, .tgt,
  .ram_addr, .sfa_addr, .code_addr, .refused, .stall);
